// *** logic/adc_pkg.sv ***
// Package of constants and types for the asynchronous DRAM host controller.
// Summary of operation
// - 64K x4 words, row/column halves on eight lines
// - Refresh all 256 rows every 4 ms
// - Row-only, hidden and column-first refresh styles
// - Wait 500 us, then eight refresh cycles
// - Write strobe before column strobe: early write
// - Non-early write keeps output enable high
// - Write strobe high until read strobes rise
// - Random cycles no closer than 200 ns
// - Read-modify-write cycle lasts at least 280 ns
// - Page column cycles no shorter than 100 ns
// - Column strobe 10 ns before row strobe
// - Counter test: row low 285, cycle 385
// - Counter test writes zeros via counter rows
// - Counter test reads zeros with external rows
// - Counter test writes ones, reads via counter
// - Write data held 35 ns after column fall
package adc_pkg;
  // ****************************************************************
  // Clock and timing figures.
  // ****************************************************************
  localparam int CLK_NS = 25;  // Clock period in ns.
  localparam int T_RC_NS = 200;  // Random cycle time.
  localparam int T_RWC_NS = 280;  // Read-modify-write cycle time.
  localparam int T_PC_NS = 100;  // Page column cycle time.
  localparam int T_RAS_NS = 100;  // Row strobe pulse width.
  localparam int T_RP_NS = 90;  // Row strobe precharge.
  localparam int T_RCD_NS = 25;  // Row to column delay, inside 20..50.
  localparam int T_CAS_NS = 50;  // Column strobe pulse width.
  localparam int T_CP_NS = 40;  // Column strobe precharge.
  localparam int T_CSR_NS = 10;  // Column before row setup.
  localparam int T_RTC_NS = 385;  // Counter test cycle time.
  localparam int T_RTRAS_NS = 285;  // Counter test row low time.
  localparam int T_DH_NS = 35;  // Write data hold from column fall.
  localparam int T_OEH_NS = 25;  // Output enable hold in late write.
  localparam int T_OFF_NS = 30;  // Device output turn-off time.
  localparam int T_RAC_NS = 100;  // Access time from row strobe.
  localparam int T_CAC_NS = 50;  // Access time from column strobe.
  localparam int T_PWR_US = 500;  // Power-up pause.
  localparam int T_REF_MS = 4;  // Refresh period.
  localparam int ROWS = 256;  // Rows to refresh.
  localparam int INIT_REFS = 8;  // Initialisation refresh cycles.
  // Least times round up to whole cycles.
  localparam int C_RCD = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CAS = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CP = (T_CP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CSR = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RTRAS = (T_RTRAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_DH = (T_DH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_OEH = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RWC = (T_RWC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PC = (T_PC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RTC = (T_RTC_NS + CLK_NS - 1) / CLK_NS;
  // Read sample point after column fall: access time, the first edge after
  // valid data, and two synchroniser stages.
  localparam int C_CAC = (T_CAC_NS + CLK_NS - 1) / CLK_NS + 3;
  localparam int C_OFF = (T_OFF_NS + CLK_NS - 1) / CLK_NS;
  // Long counts are defaults of top parameters; longest time rounds down.
  localparam int C_PWR = T_PWR_US * 1000 / CLK_NS;
  localparam int C_REFI = T_REF_MS * 1000000 / CLK_NS / ROWS;
  // ****************************************************************
  // Command codes and states.
  // ****************************************************************
  typedef enum logic [2:0] {
    ADC_CMD_READ = 3'h0,  // Random read.
    ADC_CMD_WRITE = 3'h1,  // Early write.
    ADC_CMD_OEWRITE = 3'h2,  // Output enable controlled write.
    ADC_CMD_RMW = 3'h3,  // Read-modify-write.
    ADC_CMD_ROREF = 3'h4,  // Row-only refresh at given row.
    ADC_CMD_HIDREF = 3'h5,  // Read followed by hidden refresh.
    ADC_CMD_CBRREF = 3'h6,  // Column-before-row refresh.
    ADC_CMD_CTEST = 3'h7  // Counter test cycle, write or read.
  } adc_cmd_e;
  typedef enum logic [3:0] {
    ADC_ST_PWR = 4'h0,
    ADC_ST_IDLE = 4'h1,
    ADC_ST_RAS = 4'h3,
    ADC_ST_CAS = 4'h2,
    ADC_ST_HOLD = 4'h6,
    ADC_ST_PRE = 4'h7,
    ADC_ST_CBR = 4'h5,
    ADC_ST_WR2 = 4'h4,
    ADC_ST_PAGE = 4'hc
  } adc_state_e;
endpackage

// *** logic/adc_ctrl.sv ***
// Host controller driving the strobes of a 64K x 4 asynchronous DRAM.
`timescale 1ns/10ps
module adc_ctrl #(
  parameter int PWR_CYCLES = adc_pkg::C_PWR,  // Power-up pause in cycles.
  parameter int REFI_CYCLES = adc_pkg::C_REFI  // Refresh spacing in cycles.
) (
  input wire logic mclk,  // 40 MHz clock.
  input wire logic rst,  // Synchronous reset, active high.
  input wire logic req_valid,  // Request present.
  output logic req_ready,  // Request taken this cycle.
  input wire adc_pkg::adc_cmd_e req_cmd,  // Operation code.
  input wire logic [15:0] req_addr,  // Row in [15:8], column in [7:0].
  input wire logic [3:0] req_wdata,  // Write data.
  input wire logic req_page,  // Keep row open for a page access.
  input wire logic req_ctwr,  // Counter test: 1 writes, 0 reads.
  output logic rsp_valid,  // Read data valid, one-cycle pulse.
  output logic [3:0] rsp_rdata,  // Read data.
  output logic init_done,  // Initialisation finished.
  output logic ras_n,  // Row strobe, active low.
  output logic cas_n,  // Column strobe, active low.
  output logic we_n,  // Write strobe, active low.
  output logic oe_n,  // Output enable, active low.
  output logic [7:0] mux_address,  // Shared row/column address.
  output logic [3:0] data_bus_o,  // Data toward device.
  output logic data_bus_oe,  // High while the host drives the data bus.
  input wire logic [3:0] data_bus_i  // Data from device.
);
  import adc_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    adc_state_e st;  // Sequencer state.
    logic [31:0] cnt;  // Phase counter.
    logic [9:0] cyc;  // Cycles since row strobe fell.
    logic [31:0] refc;  // Refresh interval counter.
    logic [8:0] refpend;  // Refresh backlog.
    logic [3:0] initn;  // Init refreshes still owed.
    logic init;  // Initialisation done.
    adc_cmd_e cmd;  // Operation latched.
    logic [15:0] addr;  // Address latched.
    logic [3:0] wd;  // Write data latched.
    logic page;  // Page mode latched.
    logic ctwr;  // Counter test direction.
    logic [7:0] refrow;  // Row-only refresh address.
    logic ras_n, cas_n, we_n, oe_n, doe;
    logic [7:0] ma;
    logic [3:0] dout;
    logic rv;
    logic [3:0] rd;
    logic [3:0] s1, s2;  // Data input synchroniser.
  } adc_s;
  adc_s q, d;

  // Tells whether an operation returns read data to the requester.
  // ordinary, read-modify-write, hidden refresh and counter test reads
  function automatic logic is_rd(adc_cmd_e c, logic w);
    return c == ADC_CMD_READ || c == ADC_CMD_RMW || c == ADC_CMD_HIDREF ||
           (c == ADC_CMD_CTEST && !w);
  endfunction

  // An open page takes a same-row read or write once the column has precharged.
  // page column spacing
  logic page_take;  // Same-row request accepted while the row stays open.
  assign page_take = q.st == ADC_ST_PAGE && q.cnt + 32'(C_CAC + 2) >= 32'(C_PC) &&
                     q.cnt >= 32'(C_CP) && req_valid && q.refpend == 9'h0 &&
                     (req_cmd == ADC_CMD_READ || req_cmd == ADC_CMD_WRITE) &&
                     req_addr[15:8] == q.addr[15:8];

  // Request taken when idle, initialised and no refresh is due, or by an open page.
  // The page case shows on ready too, so the requester never sees a silent take.
  assign req_ready = (q.st == ADC_ST_IDLE && q.init && q.refpend == 9'h0) || page_take;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // The next-state process steps each cycle through strobe phases.
  always_comb begin
    d = q;
    d.rv = 1'b0;
    d.s1 = data_bus_i;
    d.s2 = q.s1;
    d.cnt = q.cnt + 32'h1;
    d.cyc = (q.ras_n) ? 10'h0 : q.cyc + 10'h1;
    if (q.refc >= 32'(REFI_CYCLES - 1)) begin
      d.refc = 32'h0;
      if (q.init && q.refpend != 9'h1ff) begin
        d.refpend = q.refpend + 9'h1;
      end
    end else begin
      d.refc = q.refc + 32'h1;
    end
    case (q.st)
      ADC_ST_PWR: begin
        if (q.cnt >= 32'(PWR_CYCLES - 1)) begin
          d.st = ADC_ST_IDLE;
          d.cnt = 32'h0;
        end
      end
      ADC_ST_IDLE: begin
        d.cnt = 32'h0;
        if (!q.init || q.refpend != 9'h0) begin
          d.cmd = ADC_CMD_ROREF;
          d.addr = {q.refrow, 8'h0};
          d.refrow = q.refrow + 8'h1;
          d.page = 1'b0;
          d.ma = q.refrow;
          d.st = ADC_ST_RAS;
          if (!q.init) begin
            d.initn = q.initn - 4'h1;
          end else begin
            // A refresh tick in this same cycle is kept, not lost.
            d.refpend = d.refpend - 9'h1;
          end
        end else if (req_valid) begin
          d.cmd = req_cmd;
          d.addr = req_addr;
          d.wd = req_wdata;
          d.page = req_page;
          d.ctwr = req_ctwr;
          if (req_cmd == ADC_CMD_CBRREF || req_cmd == ADC_CMD_CTEST) begin
            // Column address settles a cycle before the column strobe falls.
            d.ma = req_addr[7:0];
            d.st = ADC_ST_CBR;
            if (req_cmd == ADC_CMD_CTEST && req_ctwr) begin
              d.we_n = 1'b0;
              d.oe_n = 1'b1;
              d.dout = req_wdata;
              d.doe = 1'b1;
            end
          end else begin
            d.ma = req_addr[15:8];
            d.st = ADC_ST_RAS;
          end
        end
      end
      ADC_ST_CBR: begin
        if (q.cas_n) begin
          // Column strobe first, the row strobe follows after the setup time.
          d.cas_n = 1'b0;
          d.cnt = 32'h0;
        end else if (q.cnt >= 32'(C_CSR - 1) && (q.oe_n || q.cnt >= 32'(C_RP - 1))) begin
          // A hidden refresh arrives with the output still enabled and the row
          // strobe just raised, so it also waits out the row precharge.
          d.ras_n = 1'b0;
          d.cnt = 32'h0;
          d.st = ADC_ST_HOLD;
        end
      end
      ADC_ST_RAS: begin
        if (q.ras_n) begin
          d.ras_n = 1'b0;
          d.cnt = 32'h0;
        end else if (q.cmd == ADC_CMD_ROREF) begin
          d.st = ADC_ST_HOLD;
        end else if (q.cnt >= 32'(C_RCD - 1)) begin
          d.ma = q.addr[7:0];
          d.cnt = 32'h0;
          d.st = ADC_ST_CAS;
          if (q.cmd == ADC_CMD_WRITE) begin
            d.we_n = 1'b0;
            d.dout = q.wd;
            d.doe = 1'b1;
          end
          d.oe_n = !is_rd(q.cmd, q.ctwr);
        end
      end
      ADC_ST_CAS: begin
        if (q.cas_n && q.cnt == 32'h0) begin
          d.cas_n = 1'b0;
        end else if (q.cnt >= 32'(C_CAC)) begin
          if (is_rd(q.cmd, 1'b0)) begin
            d.rv = 1'b1;
            d.rd = q.s2;
          end
          d.cnt = 32'h0;
          if (q.cmd == ADC_CMD_OEWRITE || q.cmd == ADC_CMD_RMW) begin
            d.oe_n = 1'b1;
            d.st = ADC_ST_WR2;
          end else begin
            d.st = ADC_ST_HOLD;
          end
        end
      end
      ADC_ST_WR2: begin
        // late write of the same address
        if (q.cnt == 32'(C_OFF)) begin
          d.dout = q.wd;
          d.doe = 1'b1;
        end else if (q.cnt == 32'(C_OFF + C_OEH)) begin
          d.we_n = 1'b0;
        end else if (q.cnt >= 32'(C_OFF + C_OEH + C_DH)) begin
          d.cnt = 32'h0;
          d.st = ADC_ST_HOLD;
        end
      end
      ADC_ST_HOLD: begin
        // counter test read
        // The output is enabled only after the row strobe has fallen, and the
        // word is taken one cycle before the row closes, long past access time.
        if (q.cmd == ADC_CMD_CTEST && !q.ctwr) begin
          d.oe_n = 1'b0;
          if (q.cyc == 10'(C_RTRAS - 1)) begin
            d.rv = 1'b1;
            d.rd = q.s2;
          end
        end
        // write data held past column fall
        if ((q.cmd == ADC_CMD_CTEST && q.cyc >= 10'(C_RTRAS)) ||
            (q.cmd != ADC_CMD_CTEST && q.cyc >= 10'(C_RAS) &&
             q.cnt >= 32'(C_DH))) begin
          if (q.page && q.cmd != ADC_CMD_CTEST && q.cmd != ADC_CMD_CBRREF &&
              q.cmd != ADC_CMD_ROREF && q.cmd != ADC_CMD_HIDREF) begin
            d.cas_n = 1'b1;
            d.we_n = 1'b1;
            d.doe = 1'b0;
            d.oe_n = 1'b1;
            d.cnt = 32'h0;
            d.st = ADC_ST_PAGE;
          end else if (q.cmd != ADC_CMD_HIDREF) begin
            d.ras_n = 1'b1;
            d.cas_n = 1'b1;
            d.we_n = 1'b1;
            d.oe_n = 1'b1;
            d.doe = 1'b0;
            d.cnt = 32'h0;
            d.st = ADC_ST_PRE;
          end else begin
            d.ras_n = 1'b1;
            d.cnt = 32'h0;
            d.cmd = ADC_CMD_CBRREF;
            d.st = ADC_ST_CBR;
          end
        end
      end
      ADC_ST_PAGE: begin
        // Column precharge, then next column if one is waiting.
        // The column cycle counts the strobe low time already spent, so the
        // bound is moved to the left side and can never wrap below zero.
        if (q.cnt + 32'(C_CAC + 2) >= 32'(C_PC) && q.cnt >= 32'(C_CP)) begin
          d.cnt = 32'h0;
          // The same test drives the ready output, so a take is always seen.
          if (page_take) begin
            d.cmd = req_cmd;
            d.addr = req_addr;
            d.wd = req_wdata;
            d.page = req_page;
            d.ma = req_addr[7:0];
            d.oe_n = req_cmd != ADC_CMD_READ;
            if (req_cmd == ADC_CMD_WRITE) begin
              d.we_n = 1'b0;
              d.dout = req_wdata;
              d.doe = 1'b1;
            end
            d.st = ADC_ST_CAS;
          end else begin
            d.ras_n = 1'b1;
            d.st = ADC_ST_PRE;
          end
        end
      end
      ADC_ST_PRE: begin
        if (q.cnt >= 32'(C_RP - 1)) begin
          d.st = ADC_ST_IDLE;
          if (q.initn == 4'h0) begin
            d.init = 1'b1;
          end
        end
      end
      default: d.st = ADC_ST_IDLE;
    endcase
  end

  // Register the whole state; reset parks every strobe inactive.
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.st <= ADC_ST_PWR;
      q.initn <= 4'(INIT_REFS);
      q.ras_n <= 1'b1;
      q.cas_n <= 1'b1;
      q.we_n <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ras_n = q.ras_n;
  assign cas_n = q.cas_n;
  assign we_n = q.we_n;
  assign oe_n = q.oe_n;
  assign mux_address = q.ma;
  assign data_bus_o = q.dout;
  assign data_bus_oe = q.doe;
  assign rsp_valid = q.rv;
  assign rsp_rdata = q.rd;
  assign init_done = q.init;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_CAS_LOW_MIN: assert property (@(posedge mclk) disable iff (rst)
    $fell(cas_n) |-> !cas_n [*2]) else $error("column strobe too short");
  AST_CBR_SETUP: assert property (@(posedge mclk) disable iff (rst)
    ($fell(ras_n) && !cas_n) |-> $past(!cas_n)) else $error("cbr setup");
  // host silent while the device may drive
  AST_NO_BUS_FIGHT: assert property (@(posedge mclk) disable iff (rst)
    data_bus_oe |-> oe_n) else $error("host drives while output enabled");
  AST_RAS_PRE: assert property (@(posedge mclk) disable iff (rst)
    $rose(ras_n) |-> ras_n [*4]) else $error("row precharge too short");
  AST_RAS_WIDTH: assert property (@(posedge mclk) disable iff (rst)
    $fell(ras_n) |-> !ras_n [*4]) else $error("row strobe too short");
  AST_EARLY_WE: assert property (@(posedge mclk) disable iff (rst)
    ($fell(cas_n) && !we_n) |-> data_bus_oe) else $error("early write no data");
  AST_WE_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    $rose(ras_n) && cas_n |-> we_n) else $error("write strobe held low");
  AST_INIT_READY: assert property (@(posedge mclk) disable iff (rst)
    req_ready |-> init_done) else $error("ready before init");
  AST_DATA_HOLD: assert property (@(posedge mclk) disable iff (rst)
    ($fell(cas_n) && !we_n) |-> data_bus_oe [*2]) else $error("data hold");
  COV_READ: cover property (@(posedge mclk) rsp_valid);
  COV_INIT: cover property (@(posedge mclk) $rose(init_done));
  COV_CBR: cover property (@(posedge mclk) $fell(ras_n) && !cas_n);
  // A read answer is a single-cycle pulse.
  AST_RSP_PULSE: assert property (@(posedge mclk) disable iff (rst)
    rsp_valid |=> !rsp_valid) else $error("read response longer than one cycle");
  COV_PAGE: cover property (@(posedge mclk) q.st == ADC_ST_PAGE);
  COV_CTEST_READ: cover property (@(posedge mclk) rsp_valid && q.cmd == ADC_CMD_CTEST);
endmodule

// *** dv/adc_dram_model.sv ***
// Behavioural model of the 64K x 4 dynamic RAM behind the controller.
`timescale 1ns/10ps
module adc_dram_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] mux_address,
  input wire logic [3:0] bus,
  output logic [3:0] dq,
  output logic dq_oe,
  output int viol
);
  logic [3:0] mem [0:65535];  // Storage cells.
  logic [7:0] row_q;  // Latched row.
  logic [7:0] col_q;  // Latched column.
  logic [7:0] cnt_q;  // Internal refresh row counter.
  logic cbr;  // Row cycle opened column first.
  logic ew;  // Early write in this column cycle.
  logic tst;  // Counter test activity in this row cycle.
  logic rmw;  // Late write seen in this row cycle.
  realtime t_ras, t_cas, t_oe, t_on, t_val;
  // Cells start at a pattern that no test writes.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 4'h9;
    {cnt_q, cbr, ew, tst, rmw, dq} = '0;
    viol = 0;
    t_ras = -1000.0;
    t_cas = -1000.0;
    t_oe = -1000.0;
    t_on = -1000.0;
    t_val = 0.0;
  end
  always @(negedge ras_n) begin
    if ($realtime - t_ras < 200.0 || (rmw && $realtime - t_ras < 280.0)) viol++;
    if (tst && $realtime - t_ras < 385.0) viol++;
    if (!cas_n && $realtime - t_cas < 10.0) viol++;
    rmw = 1'b0;
    tst = 1'b0;
    cbr = !cas_n;
    row_q = cbr ? cnt_q : mux_address;
    if (cbr) cnt_q++;
    t_ras = $realtime;
    // Counter test write with the write strobe already low: data lands at the counter row.
    if (cbr && !we_n) begin
      mem[{row_q, col_q}] = bus;
      tst = 1'b1;
    end
  end
  always @(posedge ras_n) if (tst && $realtime - t_ras < 285.0) viol++;
  always @(negedge cas_n) begin
    logic [3:0] d;
    t_cas = $realtime;
    t_val = (t_cas + 50.0 > t_ras + 100.0) ? t_cas + 50.0 : t_ras + 100.0;
    col_q = mux_address;
    ew = !we_n;
    #1;
    if (ew && !ras_n) begin
      d = bus;
      mem[{row_q, col_q}] = d;
      #34;
      if (bus !== d) viol++;
    end
  end
  always @(negedge we_n) if (!cas_n && !ras_n) begin
    if (!oe_n || dq_oe) viol++;
    #1;
    mem[{row_q, col_q}] = bus;
    rmw = 1'b1;
    tst = tst | cbr;
  end
  always @(negedge oe_n) begin
    t_oe = $realtime;
    tst = tst | (cbr & !ras_n);
  end
  // drive while selected, and keep driving for the full turn-off time after
  always #1 begin
    if (cas_n) ew = 1'b0;
    if (!cas_n && !oe_n && we_n && !ew) t_on = $realtime;
    dq_oe = $realtime - t_on < 30.0;
    if ($realtime == t_on && $realtime >= t_val && $realtime - t_oe >= 25.0) begin
      dq = mem[{row_q, col_q}];
    end else begin
      dq = ~dq;
    end
  end
endmodule

// *** dv/adc_ctrl_bench.sv ***
// Self-checking bench for the DRAM host controller.
`timescale 1ns/10ps
module adc_ctrl_bench;
  import adc_pkg::*;
  typedef struct packed {
    adc_cmd_e cmd;
    logic rd;
    logic [15:0] addr;
    logic [3:0] wd;
    logic [3:0] ex;
  } adc_row_s;
  localparam int PWR = 20;  // Shortened power-up pause.
  logic mclk, rst, req_valid, req_ready, req_page, req_ctwr, rsp_valid, init_done;
  logic ras_n, cas_n, we_n, oe_n, data_bus_oe, dq_oe, flt;
  adc_cmd_e req_cmd;
  logic [15:0] req_addr;
  logic [7:0] mux_address;
  logic [3:0] req_wdata, rsp_rdata, data_bus_o, data_bus_i, dq, got;
  int viol, n_fail, n_tests, n_ras, t0, k;
  adc_row_s rows [13] = '{
    '{ADC_CMD_WRITE, 1'b0, 16'h1234, 4'h5, 4'h0},
    '{ADC_CMD_READ, 1'b1, 16'h1234, 4'h0, 4'h5},
    '{ADC_CMD_OEWRITE, 1'b0, 16'h12ff, 4'ha, 4'h0},
    '{ADC_CMD_READ, 1'b1, 16'h12ff, 4'h0, 4'ha},
    '{ADC_CMD_RMW, 1'b1, 16'h1234, 4'hc, 4'h5},
    '{ADC_CMD_READ, 1'b1, 16'h1234, 4'h0, 4'hc},
    '{ADC_CMD_ROREF, 1'b0, 16'h3400, 4'h0, 4'h0},
    '{ADC_CMD_CBRREF, 1'b0, 16'h0000, 4'h0, 4'h0},
    '{ADC_CMD_HIDREF, 1'b1, 16'h12ff, 4'h0, 4'ha},
    '{ADC_CMD_WRITE, 1'b0, 16'hffff, 4'hf, 4'h0},
    '{ADC_CMD_READ, 1'b1, 16'hffff, 4'h0, 4'hf},
    '{ADC_CMD_WRITE, 1'b0, 16'h0000, 4'h0, 4'h0},
    '{ADC_CMD_READ, 1'b1, 16'h0000, 4'h0, 4'h0}};
  adc_ctrl #(.PWR_CYCLES(PWR), .REFI_CYCLES(200)) i_adc_ctrl (.mclk(mclk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_page(req_page), .req_ctwr(req_ctwr), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .oe_n(oe_n), .mux_address(mux_address), .data_bus_o(data_bus_o),
    .data_bus_oe(data_bus_oe), .data_bus_i(data_bus_i));
  adc_dram_model i_adc_dram_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .mux_address(mux_address), .bus(data_bus_i), .dq(dq), .dq_oe(dq_oe), .viol(viol));
  // An undriven bus shows a pattern that changes every cycle.
  assign data_bus_i = data_bus_oe ? data_bus_o : (dq_oe ? dq : {4{flt}});
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) flt <= ~flt;
  always @(negedge ras_n) n_ras++;
  // Both ends never drive the bus together.
  always @(negedge mclk) if (!rst) check({3'h0, data_bus_oe & dq_oe}, 4'h0);
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds one request until the edge where it is taken.
  task automatic issue(input adc_cmd_e c, input logic [15:0] a, input logic [3:0] d,
    input logic pg, input logic wr);
    int w;
    w = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_wdata <= d;
    req_page <= pg;
    req_ctwr <= wr;
    @(negedge mclk);
    while (req_ready !== 1'b1 && w < 4000) begin
      @(negedge mclk);
      w++;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    if (w >= 4000) check(4'h1, 4'h0);
  endtask
  // Waits a bounded time for read data.
  task automatic get(output logic [3:0] q);
    int w;
    w = 0;
    while (rsp_valid !== 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
    q = rsp_rdata;
    if (w >= 200) check(4'h1, 4'h0);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {rst, flt} = 2'b10;
    {req_valid, req_page, req_ctwr, req_addr, req_wdata} = '0;
    req_cmd = ADC_CMD_READ;
    {n_fail, n_tests, n_ras} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    n_ras = 0;
    t0 = $time;
    check({3'h0, init_done | req_ready}, 4'h0);
    for (k = 0; k < 2000 && init_done !== 1'b1; k++) @(negedge mclk);
    check(n_ras[3:0], 4'h8);
    check({3'h0, ($time - t0) >= PWR * 25}, 4'h1);
    foreach (rows[i]) begin
      issue(rows[i].cmd, rows[i].addr, rows[i].wd, 1'b0, 1'b0);
      if (rows[i].rd) begin
        get(got);
        check(got, rows[i].ex);
      end
    end
    // A refresh must come within 300 cycles, past the shortened interval; the page pair then
    // runs right after it, clear of the next one.
    k = n_ras;
    for (int j = 0; j < 300 && n_ras == k; j++) @(negedge mclk);
    check({3'h0, n_ras != k}, 4'h1);
    k = n_ras;
    issue(ADC_CMD_WRITE, 16'h4410, 4'h3, 1'b1, 1'b0);
    issue(ADC_CMD_WRITE, 16'h4411, 4'h6, 1'b0, 1'b0);
    check(4'(n_ras - k), 4'h1);
    issue(ADC_CMD_READ, 16'h4410, 4'h0, 1'b0, 1'b0);
    get(got);
    check(got, 4'h3);
    issue(ADC_CMD_READ, 16'h4411, 4'h0, 1'b0, 1'b0);
    get(got);
    check(got, 4'h6);
    for (int i = 0; i < 256; i++) issue(ADC_CMD_CTEST, 16'h005a, 4'h0, 1'b0, 1'b1);
    for (int i = 0; i < 256; i++) begin
      issue(ADC_CMD_READ, {i[7:0], 8'h5a}, 4'h0, 1'b0, 1'b0);
      get(got);
      check(got, 4'h0);
      issue(ADC_CMD_WRITE, {i[7:0], 8'h5a}, 4'hf, 1'b0, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      issue(ADC_CMD_CTEST, 16'h005a, 4'h0, 1'b0, 1'b0);
      get(got);
      check(got, 4'hf);
    end
    check({3'h0, viol != 0}, 4'h0);
    finish_test();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
endmodule
